/* File: rtl/tal_defines.svh */
// constants for the thermal alert logic
`ifndef TAL_DEFINES_SVH
`define TAL_DEFINES_SVH
`define TAL_NUM_SENSORS   3
`define TAL_SENSOR_CORE0  0
`define TAL_SENSOR_CORE1  1
`define TAL_SENSOR_HUB    2
`define TAL_ACT_WIDTH     5
`define TAL_ACT_SCI       0
`define TAL_ACT_SMI       1
`define TAL_ACT_SREF2X    2
`define TAL_ACT_MEMTHR    3
`define TAL_ACT_PERFTHR   4
`define TAL_ACT_RESET     5'h00
`endif

/* File: rtl/tal_pkg.sv */
// types shared by the thermal alert logic
package tal_pkg;
	typedef enum logic [2:0] {
		TAL_RUN  = 3'h1,
		TAL_ALRT = 3'h2,
		TAL_TRIP = 3'h4
	} tal_state_t;
endpackage : tal_pkg

/* File: rtl/tal_sensor_action.sv */
// per-sensor edge detect and programmed action pulses
`timescale 1ns/1ps
`include "tal_defines.svh"
module tal_sensor_action #(
	parameter int ACT_W = `TAL_ACT_WIDTH
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             hot_i,
	input  wire logic [ACT_W-1:0] on_assert_i,
	input  wire logic [ACT_W-1:0] on_deassert_i,
	output logic      [ACT_W-1:0] action_o
);
	logic hot_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hot_q <= 1'b0;
		end else begin
			hot_q <= hot_i;
		end
	end

	// RL3 edge actions
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			action_o <= `TAL_ACT_RESET;
		end else if (hot_i && !hot_q) begin
			action_o <= on_assert_i;
		end else if (!hot_i && hot_q) begin
			action_o <= on_deassert_i;
		end else begin
			action_o <= `TAL_ACT_RESET;
		end
	end
endmodule : tal_sensor_action

/* File: rtl/tal_thermal_alert.sv */
// thermal alert combine, external hot input, actions and shutdown
//
// Contract
// RL1 - assert hot output low while any core or hub sensor reports overheating
// RL2 - any trip or external hot makes every sensor see hot asserted; a board pull during our own drive is masked until two cycles after release
// RL3 - each sensor programmable actions on assertion and deassertion edges
// RL4 - core in deepest sleep state drops its hot contribution automatically
// RL5 - board logic may drive hot pin low when itself overheating
// RL6 - catastrophic trip halts execution and asserts open-drain shutdown low
// RL7 - external hot input passes a two-stage synchroniser first
`timescale 1ns/1ps
`include "tal_defines.svh"
module tal_thermal_alert
	import tal_pkg::*;
#(
	parameter int NS    = `TAL_NUM_SENSORS,
	parameter int ACT_W = `TAL_ACT_WIDTH
) (
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	input  wire logic [NS-1:0]       sensor_hot_i,
	input  wire logic [1:0]          deepest_core_sleep_state_i,
	input  wire logic                proc_hot_n_i,
	input  wire logic                cat_trip_i,
	input  wire logic [NS*ACT_W-1:0] on_assert_i,
	input  wire logic [NS*ACT_W-1:0] on_deassert_i,
	output logic                     proc_hot_n_o,
	output logic                     proc_hot_n_oe_o,
	output logic      [NS-1:0]       sensor_seen_hot_o,
	output logic                     system_control_interrupt_o,
	output logic                     system_management_interrupt_o,
	output logic                     sref_2x_o,
	output logic                     mem_throttle_o,
	output logic                     perf_throttle_o,
	output logic                     exec_halt_o,
	output logic                     thermal_shutdown_n_o,
	output logic                     thermal_shutdown_n_oe_o
);
	import tal_pkg::*;

	// ----------------------------------------
	// external hot input
	// ----------------------------------------
	logic ext_meta_q;
	logic ext_hot_q;
	logic own_hot_q;
	logic own_dly1_q;
	logic own_dly2_q;

	// RL7 two flop sync
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_meta_q <= 1'b0;
			ext_hot_q  <= 1'b0;
		end else begin
			ext_meta_q <= ~proc_hot_n_i;
			ext_hot_q  <= ext_meta_q;
		end
	end

	// own drive delayed like the pin, so our echo and its mask line up
	// RL5 own echo mask
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			own_dly1_q <= 1'b0;
			own_dly2_q <= 1'b0;
		end else begin
			own_dly1_q <= own_hot_q;
			own_dly2_q <= own_dly1_q;
		end
	end

	// ----------------------------------------
	// sensor combine
	// ----------------------------------------
	logic [NS-1:0] contrib;
	logic          any_trip;
	logic          ext_only;

	// RL4 sleep masks core
	always_comb begin
		contrib = sensor_hot_i;
		contrib[`TAL_SENSOR_CORE0] = sensor_hot_i[`TAL_SENSOR_CORE0]
			& ~deepest_core_sleep_state_i[0];
		contrib[`TAL_SENSOR_CORE1] = sensor_hot_i[`TAL_SENSOR_CORE1]
			& ~deepest_core_sleep_state_i[1];
	end

	assign any_trip = |contrib;
	// open drain: who pulls the pin is unknowable, so the echo of our own pull is dropped
	// limitation: a board pull during our own drive shows two cycles after we let go
	// RL5 board drives hot
	assign ext_only = ext_hot_q & ~own_dly2_q;

	// RL1 drive hot pin
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			own_hot_q <= 1'b0;
		end else begin
			own_hot_q <= any_trip;
		end
	end

	assign proc_hot_n_o    = 1'b0;
	assign proc_hot_n_oe_o = own_hot_q;

	// RL2 all sensors see hot
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sensor_seen_hot_o <= '0;
		end else begin
			sensor_seen_hot_o <= {NS{any_trip | ext_only}};
		end
	end

	// ----------------------------------------
	// per-sensor actions
	// ----------------------------------------
	logic [NS*ACT_W-1:0] act_all;
	logic [ACT_W-1:0]    act_or;

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sens
			tal_sensor_action #(.ACT_W(ACT_W)) u_act (
				.clk_i        (clk_i),
				.rstn_i       (rstn_i),
				.hot_i        (sensor_seen_hot_o[g]),
				.on_assert_i  (on_assert_i[g*ACT_W +: ACT_W]),
				.on_deassert_i(on_deassert_i[g*ACT_W +: ACT_W]),
				.action_o     (act_all[g*ACT_W +: ACT_W])
			);
		end
	endgenerate

	always_comb begin
		act_or = '0;
		for (int i = 0; i < NS; i++) begin
			act_or = act_or | act_all[i*ACT_W +: ACT_W];
		end
	end

	// RL3 control interrupt pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			system_control_interrupt_o <= 1'b0;
		end else begin
			system_control_interrupt_o <= act_or[`TAL_ACT_SCI];
		end
	end

	// RL3 management interrupt pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			system_management_interrupt_o <= 1'b0;
		end else begin
			system_management_interrupt_o <= act_or[`TAL_ACT_SMI];
		end
	end

	// RL3 self refresh pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sref_2x_o <= 1'b0;
		end else begin
			sref_2x_o <= act_or[`TAL_ACT_SREF2X];
		end
	end

	// RL3 memory throttle pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mem_throttle_o <= 1'b0;
		end else begin
			mem_throttle_o <= act_or[`TAL_ACT_MEMTHR];
		end
	end

	// RL3 performance throttle pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			perf_throttle_o <= 1'b0;
		end else begin
			perf_throttle_o <= act_or[`TAL_ACT_PERFTHR];
		end
	end

	// ----------------------------------------
	// catastrophic trip
	// ----------------------------------------
	tal_state_t state_q;
	tal_state_t state_d;
	logic       halt_q;

	// sticky until reset: cooling must not restart a part that already overheated
	// RL6 trip is sticky
	always_comb begin
		state_d = state_q;
		case (state_q)
			TAL_RUN: begin
				if (cat_trip_i) begin
					state_d = TAL_TRIP;
				end else if (own_hot_q) begin
					state_d = TAL_ALRT;
				end
			end
			TAL_ALRT: begin
				if (cat_trip_i) begin
					state_d = TAL_TRIP;
				end else if (!own_hot_q) begin
					state_d = TAL_RUN;
				end
			end
			TAL_TRIP: begin
				state_d = TAL_TRIP;
			end
			// a corrupted code fails safe into shutdown
			default: begin
				state_d = TAL_TRIP;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= TAL_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// taken from the next state so halt shows one edge after the trip, from a flop
	// RL6 halt and shutdown
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			halt_q <= 1'b0;
		end else begin
			halt_q <= (state_d == TAL_TRIP);
		end
	end

	assign exec_halt_o             = halt_q;
	assign thermal_shutdown_n_o    = 1'b0;
	assign thermal_shutdown_n_oe_o = halt_q;
endmodule : tal_thermal_alert

/* File: tb/tal_alert_sva.sv */
// checker for the thermal alert logic
`timescale 1ns/1ps
module tal_alert_sva #(
	parameter int NS	= 3,
	parameter int ACT_W	= 5
) (
	input wire logic			clk_i,
	input wire logic			rstn_i,
	input wire logic [NS-1:0]		sensor_hot_i,
	input wire logic [1:0]		deepest_core_sleep_state_i,
	input wire logic			proc_hot_n_i,
	input wire logic			cat_trip_i,
	input wire logic [NS*ACT_W-1:0]	on_assert_i,
	input wire logic [NS*ACT_W-1:0]	on_deassert_i,
	input wire logic			proc_hot_n_oe_o,
	input wire logic [NS-1:0]		sensor_seen_hot_o,
	input wire logic			system_control_interrupt_o,
	input wire logic			system_management_interrupt_o,
	input wire logic			sref_2x_o,
	input wire logic			mem_throttle_o,
	input wire logic			perf_throttle_o,
	input wire logic			exec_halt_o,
	input wire logic			thermal_shutdown_n_oe_o
);
	wire [4:0] acts = {perf_throttle_o, mem_throttle_o, sref_2x_o,
		system_management_interrupt_o, system_control_interrupt_o};
	wire [4:0] cfg = on_assert_i[4:0] | on_assert_i[9:5] | on_assert_i[14:10];
	wire [4:0] dcfg = on_deassert_i[4:0] | on_deassert_i[9:5] | on_deassert_i[14:10];
	wire hot = |(sensor_hot_i & ~{1'b0, deepest_core_sleep_state_i});
	wire allh = &sensor_seen_hot_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// pin pulled low from outside only
	sequence s_ext;
		$fell(proc_hot_n_i) && !proc_hot_n_oe_o && !sensor_hot_i ##1 !proc_hot_n_i [*2];
	endsequence
	a_hot_out: assert property (proc_hot_n_oe_o == $past(hot))
		else $error("hot drive wrong");
	a_trip_spread: assert property (sensor_hot_i[2] |=> allh)
		else $error("trip not spread");
	a_ext_sync: assert property (s_ext |=> allh)
		else $error("external hot late");
	a_act_assert: assert property ($rose(allh) |-> ##2 acts == cfg)
		else $error("assert actions wrong");
	a_act_quiet: assert property ($stable(sensor_seen_hot_o) [*3] |-> acts == 5'h00)
		else $error("stray action");
	a_act_deassert: assert property ($fell(allh) |-> ##2 acts == dcfg)
		else $error("deassert actions wrong");
	a_cat_halt: assert property (cat_trip_i |=> exec_halt_o && thermal_shutdown_n_oe_o)
		else $error("no halt on trip");
	a_halt_hold: assert property (exec_halt_o |=> exec_halt_o && thermal_shutdown_n_oe_o)
		else $error("halt dropped");
endmodule : tal_alert_sva

/* File: tb/tal_board_model.sv */
// board logic that pulls the shared hot pin low
`timescale 1ns/1ps
module tal_board_model (
	input wire logic	clk_i,
	input wire logic	hot_i,
	input wire logic	dev_oe_i,
	output logic		pin_o
);
	logic drv_q = 1'b0;
	always_ff @(posedge clk_i) begin
		drv_q <= hot_i;
	end
	// pull-up holds the pin high when released
	assign pin_o = !(drv_q || dev_oe_i);
endmodule : tal_board_model

/* File: tb/thermal_alert_logic_test.sv */
// testbench for the thermal alert logic
`timescale 1ns/1ps
module thermal_alert_logic_test;
	logic		clk_i = 0, rstn_i = 0, cat_trip_i = 0, ext_hot = 0;
	logic [2:0]	sensor_hot_i = 0;
	logic [1:0]	sleep = 0;
	wire		pin, oe, halt, sd_oe, pin_dat, sd_dat;
	wire [2:0]	seen;
	wire [4:0]	acts;
	int		fail_count = 0, check_count = 0;
	initial forever #50 clk_i = ~clk_i;
	tal_thermal_alert u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sensor_hot_i(sensor_hot_i),
		.deepest_core_sleep_state_i(sleep), .proc_hot_n_i(pin), .cat_trip_i(cat_trip_i),
		.on_assert_i(15'h1041), .on_deassert_i(15'h4100), .proc_hot_n_o(pin_dat),
		.proc_hot_n_oe_o(oe), .sensor_seen_hot_o(seen), .system_control_interrupt_o(acts[0]),
		.system_management_interrupt_o(acts[1]), .sref_2x_o(acts[2]),
		.mem_throttle_o(acts[3]), .perf_throttle_o(acts[4]), .exec_halt_o(halt),
		.thermal_shutdown_n_o(sd_dat), .thermal_shutdown_n_oe_o(sd_oe));
	tal_board_model u_board (.clk_i(clk_i), .hot_i(ext_hot), .dev_oe_i(oe), .pin_o(pin));
	// ----
	// tasks
	// ----
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task chk(input logic [4:0] got, input logic [4:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task conclude;
		$display("checks %0d fails %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task t_int;
		for (int i = 0; i < 3; i++) begin
			sensor_hot_i = 3'(1 << i);
			cyc(1);
			chk(5'(oe), 5'h01);
			chk(5'(seen), 5'h07);
			cyc(2);
			chk(acts, 5'h07);
			sensor_hot_i = 3'h0;
			cyc(1);
			chk(acts, 5'h00);
			cyc(2);
			chk(acts, 5'h18);
			chk(5'(seen), 5'h00);
			cyc(1);
			chk(acts, 5'h00);
		end
	endtask : t_int
	task t_sleep;
		sleep = 2'h1;
		sensor_hot_i = 3'h1;
		cyc(1);
		chk(5'(oe), 5'h00);
		chk(5'(seen), 5'h00);
		sleep = 2'h0;
		cyc(1);
		chk(5'(oe), 5'h01);
		sensor_hot_i = 3'h0;
		cyc(5);
	endtask : t_sleep
	task t_ext;
		ext_hot = 1;
		cyc(3);
		chk(5'(seen), 5'h00);
		cyc(1);
		chk(5'(seen), 5'h07);
		chk(5'(oe), 5'h00);
		ext_hot = 0;
		cyc(6);
	endtask : t_ext
	task t_cat;
		cat_trip_i = 1;
		cyc(1);
		cat_trip_i = 0;
		chk({3'h0, halt, sd_oe}, 5'h03);
		cyc(5);
		chk({3'h0, halt, sd_oe}, 5'h03);
		chk({3'h0, pin_dat, sd_dat}, 5'h00);
	endtask : t_cat
	task t_rst;
		rstn_i = 0;
		cyc(1);
		chk({3'h0, halt, sd_oe}, 5'h00);
		rstn_i = 1;
		cyc(2);
		chk({3'h0, halt, sd_oe}, 5'h00);
		chk(5'(seen), 5'h00);
	endtask : t_rst
	initial begin
		cyc(10);
		rstn_i = 1;
		cyc(1);
		t_int;
		t_sleep;
		t_ext;
		t_cat;
		t_rst;
		conclude;
	end
	// whole run needs well under a hundred cycles
	initial begin
		repeat (500) @(posedge clk_i);
		fail_count++;
		conclude;
	end
endmodule : thermal_alert_logic_test
bind tal_thermal_alert tal_alert_sva #(.NS(NS), .ACT_W(ACT_W)) u_sva (
	.clk_i                        (clk_i),
	.rstn_i                       (rstn_i),
	.sensor_hot_i                 (sensor_hot_i),
	.deepest_core_sleep_state_i   (deepest_core_sleep_state_i),
	.proc_hot_n_i                 (proc_hot_n_i),
	.cat_trip_i                   (cat_trip_i),
	.on_assert_i                  (on_assert_i),
	.on_deassert_i                (on_deassert_i),
	.proc_hot_n_oe_o              (proc_hot_n_oe_o),
	.sensor_seen_hot_o            (sensor_seen_hot_o),
	.system_control_interrupt_o   (system_control_interrupt_o),
	.system_management_interrupt_o(system_management_interrupt_o),
	.sref_2x_o                    (sref_2x_o),
	.mem_throttle_o               (mem_throttle_o),
	.perf_throttle_o              (perf_throttle_o),
	.exec_halt_o                  (exec_halt_o),
	.thermal_shutdown_n_oe_o      (thermal_shutdown_n_oe_o)
);
